//--- hdl/secure_boot_loader_sequencer.sv
// boot-time sequencer: bootloader session or secure boot
`timescale 1ns/1ps
`default_nettype none
module secure_boot_loader_sequencer #(
  parameter int SYNC_CYCLES = boot_seq_pkg::SYNC_WINDOW_S * boot_seq_pkg::CLK_HZ
) (
  // clock and reset
  input  wire logic                                    sys_clk,
  input  wire logic                                    rst_n,
  // start triggers and pins
  input  wire logic                                    lp_exit,
  input  wire logic [(1 << boot_seq_pkg::STIM_W)-1:0] gpio_in,
  input  wire logic                                    boot_serial_receive_sync,
  input  wire logic                                    dev_mode,
  // signed packets from the host
  input  wire boot_seq_pkg::packet_s                   pkt,
  output logic                                         pkt_ready,
  // program memory signature check and image write
  input  wire boot_seq_pkg::verify_s                   verify,
  output logic                                         verify_start,
  output logic                                         pm_write_en,
  // status
  output logic                                         cpu_release,
  output logic                                         safe_mode,
  output logic                                         session_active,
  output logic                                         loader_disabled,
  output logic                                         key_loaded
);
  import boot_seq_pkg::*;

  typedef struct packed {
    boot_state_e              st;
    logic [STIM_W-1:0]        stim_sel;
    logic                     stim_def;
    logic                     disabled;
    logic                     key;
    logic                     vstart;
    logic                     pmw;
    logic [31:0]              cnt;
  } state_s;

  state_s s_q, s_d;
  logic   pkt_ok;
  logic   stim_hit;

  assign pkt_ok   = pkt.valid && pkt.sig_ok;
  assign stim_hit = s_q.stim_def && gpio_in[s_q.stim_sel];

  always_comb begin
    s_d        = s_q;
    s_d.vstart = 1'b0;
    s_d.pmw    = 1'b0;
    if (lp_exit) begin
      s_d.st  = ST_START;
      s_d.cnt = 32'h0;
    end else begin
      unique case (s_q.st)
        ST_START: begin
          s_d.cnt = 32'h0;
          if (stim_hit && !s_q.disabled) begin
            s_d.st = ST_SESSION;
          end else if (!s_q.stim_def && !s_q.disabled) begin
            s_d.st = ST_WATCH;
          end else begin
            s_d.st     = ST_VERIFY;
            s_d.vstart = 1'b1;
          end
        end
        ST_WATCH: begin
          s_d.cnt = s_q.cnt + 32'h1;
          if (boot_serial_receive_sync) begin
            s_d.st = ST_SESSION;
          end else if (s_q.cnt >= 32'(SYNC_CYCLES - 1)) begin
            s_d.st     = ST_VERIFY;
            s_d.vstart = 1'b1;
          end
        end
        ST_VERIFY: begin
          if (verify.done) begin
            s_d.st = verify.pass ? ST_RUN : ST_SAFE;
          end
        end
        ST_SESSION: begin
          if (pkt_ok) begin
            unique case (pkt.cmd)
              CMD_PARAM_WRITE: begin
                s_d.stim_sel = pkt.stim_sel;
                s_d.stim_def = 1'b1;
              end
              CMD_LOAD_KEY: begin
                s_d.key = 1'b1;
              end
              CMD_LOAD_IMAGE: begin
                s_d.pmw = s_q.key && !s_q.disabled;
              end
              CMD_DISABLE_IF: begin
                // session ends here; a fresh check decides what runs
                s_d.disabled = 1'b1;
                s_d.st       = ST_VERIFY;
                s_d.vstart   = 1'b1;
              end
            endcase
          end
        end
        ST_RUN: begin
        end
        ST_SAFE: begin
          // safe mode is left only on lp_exit or when development reactivation applies
          if (dev_mode && !s_q.disabled && (stim_hit || boot_serial_receive_sync)) begin
            s_d.st = ST_SESSION;
          end
        end
        default: s_d.st = ST_SAFE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      s_q          <= '0;
      s_q.st       <= ST_START;
      s_q.stim_sel <= STIM_RST;
      s_q.stim_def <= STIM_DEF_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pkt_ready       = (s_q.st == ST_SESSION);
  assign verify_start    = s_q.vstart;
  assign pm_write_en     = s_q.pmw;
  assign cpu_release     = (s_q.st == ST_RUN);
  assign safe_mode       = (s_q.st == ST_SAFE);
  assign session_active  = (s_q.st == ST_SESSION);
  assign loader_disabled = s_q.disabled;
  assign key_loaded      = s_q.key;

  property p_no_run_without_pass;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == ST_VERIFY && verify.done && !verify.pass && !lp_exit) |=> safe_mode;
  endproperty
  a_no_run_without_pass: assert property (p_no_run_without_pass)
    else $error("failed signature did not reach safe state");

  property p_release_on_pass;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == ST_VERIFY && verify.done && verify.pass && !lp_exit) |=> cpu_release;
  endproperty
  a_release_on_pass: assert property (p_release_on_pass)
    else $error("passing signature did not release processor");

  property p_no_write_when_disabled;
    @(posedge sys_clk) disable iff (!rst_n)
      $past(s_q.disabled) |-> !pm_write_en;
  endproperty
  a_no_write_when_disabled: assert property (p_no_write_when_disabled)
    else $error("program memory write after interface disable");

  property p_write_needs_key;
    @(posedge sys_clk) disable iff (!rst_n)
      pm_write_en |-> $past(s_q.key) && $past(pkt_ok);
  endproperty
  a_write_needs_key: assert property (p_write_needs_key)
    else $error("image write without key or signed packet");

  property p_stim_change_in_session;
    @(posedge sys_clk) disable iff (!rst_n)
      $changed(s_q.stim_sel) |-> $past(session_active) && $past(pkt_ok);
  endproperty
  a_stim_change_in_session: assert property (p_stim_change_in_session)
    else $error("stimulus reassigned outside session");

  sequence s_start_stim;
    s_q.st == ST_START && stim_hit && !s_q.disabled && !lp_exit;
  endsequence
  property p_stim_enters;
    @(posedge sys_clk) disable iff (!rst_n)
      s_start_stim |=> session_active;
  endproperty
  a_stim_enters: assert property (p_stim_enters)
    else $error("active stimulus did not start session");

  property p_start_verifies;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == ST_START && s_q.disabled && !lp_exit) |=> verify_start ##0 s_q.st == ST_VERIFY;
  endproperty
  a_start_verifies: assert property (p_start_verifies)
    else $error("start did not launch signature check");

  property p_watch_timeout;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == ST_WATCH && s_q.cnt == 32'(SYNC_CYCLES - 1)
        && !boot_serial_receive_sync && !lp_exit) |=> verify_start;
  endproperty
  a_watch_timeout: assert property (p_watch_timeout)
    else $error("sync window expiry did not start secure boot");

  property p_sync_enters;
    @(posedge sys_clk) disable iff (!rst_n)
      (s_q.st == ST_WATCH && boot_serial_receive_sync && !lp_exit) |=> session_active;
  endproperty
  a_sync_enters: assert property (p_sync_enters)
    else $error("sync pattern did not start session");

  property p_reset_no_stim;
    @(posedge sys_clk) $rose(rst_n) |-> !s_q.stim_def;
  endproperty
  a_reset_no_stim: assert property (p_reset_no_stim)
    else $error("stimulus defined after reset");

  property p_safe_stays;
    @(posedge sys_clk) disable iff (!rst_n)
      (safe_mode && !dev_mode && !lp_exit) |=> safe_mode;
  endproperty
  a_safe_stays: assert property (p_safe_stays)
    else $error("safe state left without development mode");

  property p_bad_sig_ignored;
    @(posedge sys_clk) disable iff (!rst_n)
      (session_active && pkt.valid && !pkt.sig_ok && !lp_exit)
        |=> session_active && !pm_write_en && $stable(s_q.key) && $stable(s_q.stim_sel);
  endproperty
  a_bad_sig_ignored: assert property (p_bad_sig_ignored)
    else $error("unsigned packet was acted on");
endmodule
`default_nettype wire

//--- hdl/boot_seq_pkg.sv
// constants, types and rule summary for the boot sequencer
// Summary of operation
// - Sample stimulus at start; active enters bootloader
// - Act only on packets with verified signature
// - Stimulus reassignment allowed only inside session
// - Disable command blocks later program memory changes
// - Verify program memory signature every start; skipped here when a stimulus or serial sync opens a session
// - Signature failure holds device in safe state; here lp_exit restarts the sequence from ST_START
// - Development mode lets bootloader reactivate after failure
// - Images need loaded customer key first
// - No stimulus: watch serial sync within 6s
// - No stimulus assigned by default; parameter write sets
package boot_seq_pkg;
  localparam int  SYNC_WINDOW_S   = 6;
  localparam int  CLK_HZ          = 40000000;
  localparam int  STIM_W          = 6;
  localparam logic [STIM_W-1:0] STIM_RST = 6'h00;
  localparam logic STIM_DEF_RST   = 1'b0;

  typedef enum logic [2:0] {
    ST_START   = 3'b000,
    ST_WATCH   = 3'b001,
    ST_VERIFY  = 3'b010,
    ST_SESSION = 3'b011,
    ST_RUN     = 3'b100,
    ST_SAFE    = 3'b101
  } boot_state_e;

  typedef enum logic [1:0] {
    CMD_PARAM_WRITE = 2'b00,
    CMD_LOAD_KEY    = 2'b01,
    CMD_LOAD_IMAGE  = 2'b10,
    CMD_DISABLE_IF  = 2'b11
  } boot_cmd_e;

  // one packet as delivered by the transport and signature engine
  typedef struct packed {
    logic             valid;
    logic             sig_ok;
    boot_cmd_e        cmd;
    logic [STIM_W-1:0] stim_sel;
  } packet_s;

  // verify engine answer: done and pass
  typedef struct packed {
    logic done;
    logic pass;
  } verify_s;
endpackage

//--- bench/host_pkt_model.sv
// host model: sends signed or unsigned packets to the sequencer
`timescale 1ns/1ps
`default_nettype none
module host_pkt_model
  import boot_seq_pkg::*;
(
  // clock
  input  wire logic             sys_clk,
  // packets to the device
  output boot_seq_pkg::packet_s pkt
);
  initial pkt = '0;
  // one packet held for one edge; idle fields flip so stale data never matches
  task automatic send(input boot_cmd_e c, input logic [STIM_W-1:0] s, input logic ok);
    pkt <= '{1'b1, ok, c, s};
    @(posedge sys_clk);
    pkt <= '{1'b0, ~ok, boot_cmd_e'(~c), ~s};
  endtask
endmodule
`default_nettype wire

//--- bench/tb_secure_boot_loader_sequencer.sv
// self-checking bench for the boot sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_secure_boot_loader_sequencer;
  import boot_seq_pkg::*;
  localparam int SYNC_N = 20;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        lp_exit = 1'b0;
  logic        sync = 1'b0;
  logic        dev_mode = 1'b0;
  logic [63:0] gpio_in = '0;
  verify_s     verify = '0;
  packet_s     pkt;
  logic        pkt_ready, verify_start, pm_write_en, cpu_release;
  logic        safe_mode, session_active, loader_disabled, key_loaded;
  int          error_cnt = 0, total_checks = 0, cyc = 0, vs_n = 0, pm_n = 0;

  always #12.5 sys_clk = ~sys_clk;

  // pulses counted here so no one-cycle output is missed
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    vs_n <= vs_n + int'(verify_start === 1'b1);
    pm_n <= pm_n + int'(pm_write_en === 1'b1);
    if (cyc == 2000) begin
      error_cnt++;
      finish_test();
    end
  end

  host_pkt_model u_host_pkt_model (.sys_clk(sys_clk), .pkt(pkt));

  secure_boot_loader_sequencer #(.SYNC_CYCLES(SYNC_N)) u_secure_boot_loader_sequencer (
    .sys_clk(sys_clk), .rst_n(rst_n), .lp_exit(lp_exit), .gpio_in(gpio_in),
    .boot_serial_receive_sync(sync), .dev_mode(dev_mode), .pkt(pkt),
    .pkt_ready(pkt_ready), .verify(verify), .verify_start(verify_start),
    .pm_write_en(pm_write_en), .cpu_release(cpu_release), .safe_mode(safe_mode),
    .session_active(session_active), .loader_disabled(loader_disabled),
    .key_loaded(key_loaded));

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic reset_dut;
    rst_n <= 1'b0;
    tick(4);
    rst_n <= 1'b1;
    tick(2);
  endtask

  task automatic sync_pulse;
    sync <= 1'b1;
    tick(1);
    sync <= 1'b0;
    tick(2);
  endtask

  task automatic lp_pulse;
    lp_exit <= 1'b1;
    tick(1);
    lp_exit <= 1'b0;
    tick(3);
  endtask

  task automatic vdone(input logic p);
    verify <= '{1'b1, p};
    tick(1);
    verify <= '0;
    tick(2);
  endtask

  // two edges after the take so the pulse counters have settled
  task automatic tx(input boot_cmd_e c, input logic [5:0] s, input logic ok);
    u_host_pkt_model.send(c, s, ok);
    tick(2);
  endtask

  task automatic t_session;
    reset_dut();
    sync_pulse();
    chk("session_active", 8'h01, session_active);
    chk("pkt_ready", 8'h01, pkt_ready);
    tx(CMD_LOAD_KEY, 6'h00, 1'b0);
    chk("key_loaded", 8'h00, key_loaded);
    tx(CMD_LOAD_IMAGE, 6'h00, 1'b1);
    chk("pm_writes", 8'h00, 8'(pm_n));
    tx(CMD_LOAD_KEY, 6'h00, 1'b1);
    chk("key_loaded", 8'h01, key_loaded);
    tx(CMD_LOAD_IMAGE, 6'h00, 1'b1);
    chk("pm_writes", 8'h01, 8'(pm_n));
    tx(CMD_PARAM_WRITE, 6'h05, 1'b1);
    chk("session_active", 8'h01, session_active);
    $display("test session done");
  endtask

  task automatic t_stim;
    gpio_in <= 64'h20;
    lp_pulse();
    chk("session_active", 8'h01, session_active);
    gpio_in <= '0;
    tx(CMD_DISABLE_IF, 6'h00, 1'b1);
    chk("loader_disabled", 8'h01, loader_disabled);
    chk("verify_starts", 8'h01, 8'(vs_n));
    tx(CMD_LOAD_IMAGE, 6'h00, 1'b1);
    chk("pm_writes", 8'h01, 8'(pm_n));
    vdone(1'b0);
    chk("safe_mode", 8'h01, safe_mode);
    chk("cpu_release", 8'h00, cpu_release);
    gpio_in <= 64'h20;
    lp_pulse();
    chk("session_active", 8'h00, session_active);
    chk("verify_starts", 8'h02, 8'(vs_n));
    $display("test stimulus done");
  endtask

  task automatic t_dev;
    gpio_in <= '1;
    reset_dut();
    tick(SYNC_N - 1);
    chk("verify_start", 8'h00, verify_start);
    tick(1);
    chk("verify_start", 8'h01, verify_start);
    tick(4);
    chk("session_active", 8'h00, session_active);
    chk("verify_starts", 8'h03, 8'(vs_n));
    vdone(1'b0);
    chk("safe_mode", 8'h01, safe_mode);
    dev_mode <= 1'b1;
    sync_pulse();
    chk("session_active", 8'h01, session_active);
    tx(CMD_DISABLE_IF, 6'h00, 1'b1);
    vdone(1'b1);
    chk("cpu_release", 8'h01, cpu_release);
    chk("safe_mode", 8'h00, safe_mode);
    $display("test development done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    t_session();
    t_stim();
    t_dev();
    finish_test();
  end
endmodule
`default_nettype wire
